// ### rtl/tcp_timer.sv
// design: one 16-bit timer channel with compare match, pulse output and axi4-lite registers
module tcp_timer #(
    parameter int CNT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic count_en,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_output_pin,
    output logic period_match_irq,
    output logic duty_match_irq
);
    // elaboration check: compare registers are 16 bits on the bus
    if (CNT_W != 16) begin : g_width_chk
        $error("tcp_timer supports CNT_W = 16 only");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0] timer_mode_control;         // mode, run bits, overflow
    logic [CNT_W-1:0] count_register;       // live count
    logic [CNT_W-1:0] period_compare;       // clears count on match
    logic [CNT_W-1:0] duty_compare;         // toggles output on match
    logic [3:0] out_ctl;                    // toggle enables and level bits
    logic [1:0] irq_flag;                   // sticky match flags
    logic [1:0] irq_mask;                   // masks, 1 = masked
    logic running;                          // run bits nonzero
    tcp_pkg::tcp_match_s hit;               // match events this tick
    logic aw_held;                          // write address captured
    logic w_held;                           // write data captured
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;                          // both halves present
    logic [7:0] wr_byte0;                   // merged low byte for mode

    ////////////////////////////////////////////////////////////////////////////////
    // run decode and matches
    assign running = timer_mode_control[tcp_pkg::RUN_HI_BIT]
        | timer_mode_control[tcp_pkg::RUN_LO_BIT];
    assign hit.period_hit = running && count_en
        && (count_register == period_compare);
    assign hit.duty_hit = running && count_en
        && (count_register == duty_compare);

    ////////////////////////////////////////////////////////////////////////////////
    // write channels: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_byte0 = w_strb[0] ? w_data[7:0] : timer_mode_control;

    // capture write address and data, then respond
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tcp_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                // response follows both halves
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (aw_addr)
                    tcp_pkg::MODE_OFS, tcp_pkg::COUNT_OFS, tcp_pkg::PERIOD_OFS,
                    tcp_pkg::DUTY_OFS, tcp_pkg::OUTCTL_OFS, tcp_pkg::IRQ_OFS:
                        s_axi_bresp <= tcp_pkg::RESP_OKAY;
                    default:
                        s_axi_bresp <= tcp_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode register: software writes, overflow set by hardware
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_mode_control <= tcp_pkg::MODE_RST;
        else
        begin
            if (wr_fire && aw_addr == tcp_pkg::MODE_OFS)
                timer_mode_control <= wr_byte0;
            // overflow: count wraps past all ones; set wins over clear
            if (running && count_en && !hit.period_hit && &count_register)
                timer_mode_control[tcp_pkg::OVF_BIT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare and output control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            period_compare <= tcp_pkg::PERIOD_RST;
            duty_compare <= tcp_pkg::DUTY_RST;
            out_ctl <= tcp_pkg::OUTCTL_RST;
            irq_mask <= tcp_pkg::MASK_RST;
        end
        else if (wr_fire)
        begin
            if (aw_addr == tcp_pkg::PERIOD_OFS)
            begin
                if (w_strb[0]) period_compare[7:0] <= w_data[7:0];
                if (w_strb[1]) period_compare[15:8] <= w_data[15:8];
            end
            if (aw_addr == tcp_pkg::DUTY_OFS)
            begin
                if (w_strb[0]) duty_compare[7:0] <= w_data[7:0];
                if (w_strb[1]) duty_compare[15:8] <= w_data[15:8];
            end
            if (aw_addr == tcp_pkg::OUTCTL_OFS && w_strb[0])
                out_ctl <= w_data[3:0];
            if (aw_addr == tcp_pkg::IRQ_OFS && w_strb[1])
                irq_mask <= w_data[tcp_pkg::DUTY_MASK_BIT:tcp_pkg::PERIOD_MASK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter: runs while run bits nonzero, cleared on period match
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            count_register <= '0;
        else if (!running)
            count_register <= '0;
        else if (count_en)
        begin
            if (hit.period_hit)
                count_register <= '0;
            else
                count_register <= count_register + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky match flags: write one to clear, a new match wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_flag <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if ((i == 0) ? hit.period_hit : hit.duty_hit)
                    irq_flag[i] <= 1'b1;
                else if (wr_fire && aw_addr == tcp_pkg::IRQ_OFS && w_strb[0] && w_data[i])
                    irq_flag[i] <= 1'b0;
            end
        end
    end

    assign period_match_irq = irq_flag[tcp_pkg::PERIOD_FLAG_BIT] & !irq_mask[0];
    assign duty_match_irq = irq_flag[tcp_pkg::DUTY_FLAG_BIT] & !irq_mask[1];

    ////////////////////////////////////////////////////////////////////////////////
    // timer output: toggles on matches while running, level bits while stopped
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            timer_output_pin <= 1'b0;
        else if (running)
        begin
            if ((hit.duty_hit && out_ctl[tcp_pkg::TOGGLE_EN_BIT])
                ^ (hit.period_hit && out_ctl[tcp_pkg::PERIOD_TOGGLE_BIT]))
                timer_output_pin <= !timer_output_pin;
        end
        else if (out_ctl[tcp_pkg::LVL_SET_BIT] && !out_ctl[tcp_pkg::LVL_RESET_BIT])
            timer_output_pin <= 1'b1;
        else if (!out_ctl[tcp_pkg::LVL_SET_BIT] && out_ctl[tcp_pkg::LVL_RESET_BIT])
            timer_output_pin <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read channel: one read at a time, data from flip-flops
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tcp_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tcp_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                tcp_pkg::MODE_OFS: s_axi_rdata <= {24'h000000, timer_mode_control};
                tcp_pkg::COUNT_OFS: s_axi_rdata <= {16'h0000, count_register};
                tcp_pkg::PERIOD_OFS: s_axi_rdata <= {16'h0000, period_compare};
                tcp_pkg::DUTY_OFS: s_axi_rdata <= {16'h0000, duty_compare};
                tcp_pkg::OUTCTL_OFS: s_axi_rdata <= {28'h0000000, out_ctl};
                tcp_pkg::IRQ_OFS: s_axi_rdata <= {22'h000000, irq_mask, 6'h00, irq_flag};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= tcp_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    stop_clears_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !running |=> count_register == '0)
        else $error("count not zero while stopped");
    period_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hit.period_hit |=> count_register == '0 && irq_flag[0])
        else $error("period match did not clear count or set flag");
    duty_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
        hit.duty_hit && !hit.period_hit |=> irq_flag[1]
        && count_register == $past(count_register) + 16'h0001)
        else $error("duty match misbehaved");
    toggle_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        running && !out_ctl[0] && !out_ctl[3] |=> $stable(timer_output_pin))
        else $error("output changed with toggling off");
    pulse_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
        running && hit.duty_hit && out_ctl[0] && !hit.period_hit
        |=> timer_output_pin != $past(timer_output_pin))
        else $error("output did not toggle on duty match");
    level_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !running && out_ctl[2:1] == 2'h2 |=> timer_output_pin)
        else $error("level set did not drive high");
    level_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !running && out_ctl[2:1] == 2'h1 |=> !timer_output_pin)
        else $error("level reset did not drive low");
    mode_reset_a: assert property (@(posedge aclk)
        !aresetn |=> timer_mode_control == tcp_pkg::MODE_RST)
        else $error("mode register not cleared by reset");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    period_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) hit.period_hit);
    duty_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) hit.duty_hit && out_ctl[0]);
    ovf_cov_c: cover property (@(posedge aclk) disable iff (!aresetn) timer_mode_control[0]);
endmodule : tcp_timer

// ### shared/tcp_pkg.sv
// package: register map, field positions and reset values of the timer compare pulse block
package tcp_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] MODE_OFS = 8'h00;      // timer_mode_control
    localparam logic [7:0] COUNT_OFS = 8'h04;     // count_register, read only
    localparam logic [7:0] PERIOD_OFS = 8'h08;    // period_compare
    localparam logic [7:0] DUTY_OFS = 8'h0c;      // duty_compare
    localparam logic [7:0] OUTCTL_OFS = 8'h10;    // output control
    localparam logic [7:0] IRQ_OFS = 8'h14;       // match flags and masks
    // timer_mode_control fields
    localparam int RUN_LO_BIT = 2;                // run_mode_bit_low
    localparam int RUN_HI_BIT = 3;                // run_mode_bit_high
    localparam int OVF_BIT = 0;                   // overflow_flag
    // output control fields
    localparam int TOGGLE_EN_BIT = 0;             // duty_match_toggle_enable
    localparam int LVL_RESET_BIT = 1;             // output_level_reset
    localparam int LVL_SET_BIT = 2;               // output_level_set
    localparam int PERIOD_TOGGLE_BIT = 3;         // toggle on period match
    // irq register fields
    localparam int PERIOD_FLAG_BIT = 0;
    localparam int DUTY_FLAG_BIT = 1;
    localparam int PERIOD_MASK_BIT = 8;
    localparam int DUTY_MASK_BIT = 9;             // duty_irq_mask
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] DUTY_RST = 16'h0000;
    localparam logic [3:0] OUTCTL_RST = 4'h0;
    localparam logic [1:0] MASK_RST = 2'h3;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // match event carrier
    typedef struct packed {
        logic period_hit;   // count equals period_compare
        logic duty_hit;     // count equals duty_compare
    } tcp_match_s;
endpackage : tcp_pkg

// ### sim/tcp_pin_monitor.sv
// partner: circuit on the timer output pin, measures pulse period and high width
module tcp_pin_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timer_output_pin,
    output logic [15:0] period_cycles,
    output logic [15:0] high_cycles,
    output logic [15:0] n_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cyc; // free running cycle stamp
    logic [15:0] last_rise; // stamp of the latest rising edge
    logic pin_d; // pin one cycle ago
    // edge detection and width measurement
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc <= 16'h0000;
            last_rise <= 16'h0000;
            pin_d <= 1'b0;
            period_cycles <= 16'h0000;
            high_cycles <= 16'h0000;
            n_rises <= 16'h0000;
        end
        else
        begin
            cyc <= cyc + 16'h0001;
            pin_d <= timer_output_pin;
            // rise: one full pulse period has elapsed
            if (timer_output_pin && !pin_d)
            begin
                period_cycles <= cyc - last_rise;
                last_rise <= cyc;
                n_rises <= n_rises + 16'h0001;
            end
            // fall: high phase ends
            if (!timer_output_pin && pin_d)
                high_cycles <= cyc - last_rise;
        end
    end
endmodule : tcp_pin_monitor

// ### sim/tcp_timer_tb_top.sv
// testbench: register, level and pulse scenarios for the timer channel
module tcp_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, count_en, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pin, p_irq, d_irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [15:0] per_cyc, hi_cyc, n_rises;
    logic slow; // halves the count tick rate while set
    int n_errors, total_checks;
    ////////////////////////////////////////////////////////////////////////////////
    tcp_timer i_tcp_timer (.aclk(aclk), .aresetn(aresetn), .count_en(count_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_output_pin(pin),
        .period_match_irq(p_irq), .duty_match_irq(d_irq));
    tcp_pin_monitor i_tcp_pin_monitor (.aclk(aclk), .aresetn(aresetn),
        .timer_output_pin(pin), .period_cycles(per_cyc), .high_cycles(hi_cyc),
        .n_rises(n_rises));
    ////////////////////////////////////////////////////////////////////////////////
    // 25 mhz clock
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // count tick: every cycle, or every second cycle while slow is set
    always @(posedge aclk)
        count_en <= aresetn && !(slow && count_en);
    // compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // verdict and end of run
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask : wr
    // axi4-lite read
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask : rd_reg
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a);
        check(what, rd, exp);
    endtask : rdchk
    // wait for k more rising edges on the pin; the watchdog bounds the wait
    task automatic wait_rises(input int k);
        int s;
        s = n_rises;
        while (n_rises < s + k)
            @(posedge aclk);
    endtask : wait_rises
    ////////////////////////////////////////////////////////////////////////////////
    // reset values and the unmapped address
    task automatic t_reset();
        rdchk("mode", tcp_pkg::MODE_OFS, 32'h0000_0000);
        rdchk("period", tcp_pkg::PERIOD_OFS, 32'h0000_ffff);
        rdchk("duty", tcp_pkg::DUTY_OFS, 32'h0000_0000);
        rdchk("count", tcp_pkg::COUNT_OFS, 32'h0000_0000);
        rdchk("irq", tcp_pkg::IRQ_OFS, 32'h0000_0300);
        check("pin after reset", pin, 1'b0);
        rd_reg(8'h20);
        check("unmapped rresp", rsp, tcp_pkg::RESP_SLVERR);
        wr(8'h20, 32'h0000_00ff);
        check("unmapped bresp", rsp, tcp_pkg::RESP_SLVERR);
    endtask : t_reset
    // manual level control while stopped: set, hold, prohibited, clear
    task automatic t_levels();
        logic [31:0] code [4] = '{32'h4, 32'h0, 32'h6, 32'h2};
        logic exp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            wr(tcp_pkg::OUTCTL_OFS, code[i]);
            repeat (2) @(posedge aclk);
            check("pin level", pin, exp[i]);
        end
    endtask : t_levels
    // pulse mode: period 20 ticks, high from duty match to period match
    task automatic t_pulse();
        wr(tcp_pkg::PERIOD_OFS, 32'd19);
        check("mapped bresp", rsp, tcp_pkg::RESP_OKAY);
        wr(tcp_pkg::DUTY_OFS, 32'd4);
        wr(tcp_pkg::IRQ_OFS, 32'h0);
        wr(tcp_pkg::OUTCTL_OFS, 32'h9);
        wr(tcp_pkg::MODE_OFS, 32'h4);
        wait_rises(3);
        check("pulse period", per_cyc, 16'd20);
        check("pulse high", hi_cyc, 16'd15);
        check("period irq", p_irq, 1'b1);
        check("duty irq", d_irq, 1'b1);
        rd_reg(tcp_pkg::COUNT_OFS);
        check("count bound", 32'(rd <= 32'd19), 32'h1);
    endtask : t_pulse
    // duty change while running, right after the duty match
    task automatic t_duty_change();
        wait_rises(1);
        wr(tcp_pkg::IRQ_OFS, 32'h200);
        check("masked duty irq", d_irq, 1'b0);
        wr(tcp_pkg::OUTCTL_OFS, 32'h8);
        wr(tcp_pkg::DUTY_OFS, 32'd9);
        @(posedge aclk);
        wr(tcp_pkg::OUTCTL_OFS, 32'h9);
        wr(tcp_pkg::IRQ_OFS, 32'h202);
        wr(tcp_pkg::IRQ_OFS, 32'h0);
        wait_rises(3);
        check("new high", hi_cyc, 16'd10);
        check("new period", per_cyc, 16'd20);
    endtask : t_duty_change
    // stop, count held at zero, flags cleared
    task automatic t_stop();
        wr(tcp_pkg::MODE_OFS, 32'h0);
        rdchk("stopped count", tcp_pkg::COUNT_OFS, 32'h0);
        wr(tcp_pkg::IRQ_OFS, 32'h3);
        rdchk("flags cleared", tcp_pkg::IRQ_OFS, 32'h0);
        check("irq low", p_irq, 1'b0);
        check("duty irq low", d_irq, 1'b0);
    endtask : t_stop
    // toggling disabled: matches happen, pin stays put
    task automatic t_toggle_off();
        wr(tcp_pkg::OUTCTL_OFS, 32'h2);
        wr(tcp_pkg::OUTCTL_OFS, 32'h0);
        wr(tcp_pkg::MODE_OFS, 32'h8);
        rdchk("mode readback", tcp_pkg::MODE_OFS, 32'h8);
        repeat (60) @(posedge aclk);
        check("pin untoggled", pin, 1'b0);
        rdchk("flags set", tcp_pkg::IRQ_OFS, 32'h3);
        wr(tcp_pkg::MODE_OFS, 32'h0);
    endtask : t_toggle_off
    // slow count tick: pulse period and width stretch by two
    task automatic t_prescale();
        slow <= 1'b1;
        wr(tcp_pkg::OUTCTL_OFS, 32'h9);
        wr(tcp_pkg::MODE_OFS, 32'h4);
        wait_rises(3);
        check("slow period", per_cyc, 16'd40);
        check("slow high", hi_cyc, 16'd20);
        wr(tcp_pkg::MODE_OFS, 32'h0);
    endtask : t_prescale
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {aresetn, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_levels();
        t_pulse();
        t_duty_change();
        t_stop();
        t_toggle_off();
        t_prescale();
        report_and_stop();
    end
    // watchdog
    initial
    begin
        repeat (5000) @(posedge aclk);
        n_errors++;
        report_and_stop();
    end
endmodule : tcp_timer_tb_top
